// ---- pkg/mrs_pkg.sv ----
package mrs_pkg;

  // Register offsets
  localparam logic [15:0] MRS_RAM_FIRST = 16'h4380;
  localparam logic [15:0] MRS_RAM_LAST = 16'h43BF;
  localparam logic [15:0] MRS_A_IGAIN = 16'h4380;
  localparam logic [15:0] MRS_B_IGAIN = 16'h4383;
  localparam logic [15:0] MRS_C_IGAIN = 16'h4386;
  localparam logic [15:0] MRS_N_IGAIN = 16'h4389;
  localparam logic [15:0] MRS_DSP_RUN = 16'hE228;
  localparam logic [15:0] MRS_ACT_ACC = 16'hE400;
  localparam logic [15:0] MRS_REACT_ACC = 16'hE401;
  localparam logic [15:0] MRS_APP_ACC = 16'hE402;
  localparam logic [15:0] MRS_STATUS_ONE = 16'hE503;
  localparam logic [15:0] MRS_PULSE_MODE = 16'hE610;
  localparam logic [15:0] MRS_CHIP_SETUP = 16'hE618;
  localparam logic [15:0] MRS_THIRD_SETUP = 16'hE708;
  localparam logic [15:0] MRS_PROT_KEY2 = 16'hE7E3;
  localparam logic [15:0] MRS_PROT_KEY1 = 16'hE7FE;
  localparam logic [15:0] MRS_SERIAL_LOCK = 16'hEA00;

  // Field positions
  localparam int MRS_RDONE_BIT = 15;
  localparam int MRS_PO1_DIS_BIT = 9;
  localparam int MRS_SOFTWARE_RESET_BIT_BIT = 7;
  localparam int MRS_REMRST_BIT = 7;
  localparam int MRS_CLKDIS_BIT = 6;
  localparam int MRS_LOCK_BIT = 0;
  localparam int MRS_SPI_BIT = 1;

  // Values and reset defaults
  localparam logic [15:0] MRS_RUN_START = 16'h0001;
  localparam logic [7:0] MRS_KEY1_VAL = 8'hAD;
  localparam logic [7:0] MRS_KEY2_VAL = 8'h80;
  localparam logic [15:0] MRS_PULSE_MODE_RST = 16'h0E00;
  localparam logic [15:0] MRS_CHIP_SETUP_RST = 16'h0000;
  localparam logic [7:0] MRS_THIRD_SETUP_RST = 8'h00;

  // Remote reset timing: main clock divided by four, eight toggles
  localparam logic [1:0] MRS_DIV_LAST = 2'h3;
  localparam logic [2:0] MRS_TOG_LAST = 3'h7;
  localparam logic [1:0] MRS_SS_SPI_COUNT = 2'h3;

  typedef enum logic [3:0] {
    MRS_HOLD = 4'h1,
    MRS_SEQ = 4'h2,
    MRS_RUN = 4'h4,
    MRS_LOWPWR = 4'h8
  } mrs_state_e;

endpackage

// ---- verilog/mrs_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module mrs_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } mrs_sync_s;

  mrs_sync_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // Accept a change only once the second and third stages agree
    if (s_q.s2 == s_q.s3) begin
      s_d.val = s_q.s3;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.val;

endmodule

`default_nettype wire

// ---- verilog/mrs_dsp_ram.sv ----
`timescale 1ns/1ps
`default_nettype none

module mrs_dsp_ram (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic wr,
  input wire logic [5:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [5:0] raddr,
  output logic [31:0] rdata
);
  typedef struct packed {
    logic [63:0] valid;
    logic [63:0][31:0] mem;
    logic [31:0] rdata;
  } mrs_ram_s;

  mrs_ram_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    // Unwritten words read as their default of zero
    s_d.rdata = s_q.valid[raddr] ? s_q.mem[raddr] : 32'h0000_0000;
    if (clear) begin
      s_d.valid = '0;
    end else if (wr) begin
      s_d.mem[waddr] = wdata;
      s_d.valid[waddr] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;

endmodule

`default_nettype wire

// ---- verilog/mrs_sequencer.sv ----
// How it works
// - On I2C, writing 1 to lock bit 0 locks the port to I2C.
// - On SPI, any write to the serial-lock register locks the port to SPI.
// - A locked port ignores protocol changes until power-down or hardware reset.
// - Writing 0x0001 to the run register starts the signal processor.
// - Key 0xAD at 0xE7FE then 0x80 at 0xE7E3 write-protects DSP RAM.
// - Reading an energy accumulator clears it to zero.
// - Pulse-mode bits 9..11 disable the three pulse outputs; clear enables.
// - Hardware reset low: clock output stopped high, sync, enable, toggles high.
// - After reset release, enable goes low and toggles pulse eight times.
// - Enable returning high after hardware reset restarts the divided clock.
// - Hardware or chipset reset end sets reset-done bit 15 and pulls interrupt-one low.
// - Writing 1 to reset-done clears it and releases interrupt-one high.
// - Hardware reset selects I2C; SPI users reselect SPI afterwards.
// - Hardware reset returns all registers to default, processor idle.
// - Chip-setup bit 7 resets all registers except the energy accumulators and keeps a locked port.
// - Chipset reset ends by clearing its bit, processor left idle.
// - Chipset reset keeps clock running while doing the remote sequence.
// - Third-setup bit 7 resets only the remote converters, then self-clears.
// - Third-setup bits 6 and 7 both set enter low power mode.
// - Clearing both bits leaves low power mode with configuration retained.
// - Reset-done cannot be masked; interrupt-one stays low until cleared.
// - Three high-to-low slave-select toggles switch the port to SPI.
`timescale 1ns/1ps
`default_nettype none

module mrs_sequencer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic slave_select_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [31:0] active_energy_inc,
  input wire logic [31:0] reactive_energy_inc,
  input wire logic [31:0] apparent_energy_inc,
  input wire logic stream_sync,
  output logic remote_clock_output,
  output logic remote_sync,
  output logic remote_reset_en,
  output logic channel_a_toggle,
  output logic channel_b_toggle,
  output logic channel_c_toggle,
  output logic neutral_toggle,
  output logic interrupt_one_output_n,
  output logic spi_selected,
  output logic port_locked,
  output logic dsp_running,
  output logic [2:0] pulse_out_en,
  output logic ram_protected,
  output logic low_power,
  output mrs_pkg::mrs_state_e seq_state
);
  import mrs_pkg::*;

  typedef struct packed {
    mrs_state_e state;
    logic is_hw;
    logic is_chip;
    logic [1:0] div;
    logic [2:0] cnt;
    logic spi;
    logic locked;
    logic [1:0] ss_cnt;
    logic ss_prev;
    logic run;
    logic rdone;
    logic [15:0] pmode;
    logic [15:0] csetup;
    logic [7:0] cfg3;
    logic key_armed;
    logic protect;
    logic [2:0][31:0] acc;
    logic [31:0] rdata;
    logic rvalid;
    logic ram_sel;
    logic rclk;
    logic rsync;
    logic ren;
    logic tog;
  } mrs_seq_s;

  localparam mrs_seq_s MRS_SEQ_RST = '{
    state: MRS_HOLD,
    is_hw: 1'b1,
    is_chip: 1'b0,
    div: 2'h0,
    cnt: 3'h0,
    spi: 1'b0,
    locked: 1'b0,
    ss_cnt: 2'h0,
    ss_prev: 1'b1,
    run: 1'b0,
    rdone: 1'b0,
    pmode: MRS_PULSE_MODE_RST,
    csetup: MRS_CHIP_SETUP_RST,
    cfg3: MRS_THIRD_SETUP_RST,
    key_armed: 1'b0,
    protect: 1'b0,
    acc: '0,
    rdata: 32'h0000_0000,
    rvalid: 1'b0,
    ram_sel: 1'b0,
    rclk: 1'b1,
    rsync: 1'b1,
    ren: 1'b1,
    tog: 1'b1
  };

  function automatic logic is_ram(input logic [15:0] a);
    is_ram = (a >= MRS_RAM_FIRST) && (a <= MRS_RAM_LAST);
  endfunction

  function automatic logic [5:0] ram_index(input logic [15:0] a);
    logic [15:0] off;
    off = a - MRS_RAM_FIRST;
    ram_index = off[5:0];
  endfunction

  mrs_seq_s s_q, s_d;
  logic hw_run;
  logic ss_level;
  logic ram_clear;
  logic ram_wr;
  logic [31:0] ram_rdata;
  logic clock_on;
  logic [2:0][31:0] inc;
  logic [2:0] acc_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and DSP RAM

  mrs_pin_sync #(.RST_VAL(1'b0)) u_rst_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(reset_pin_n),
    .level(hw_run)
  );

  mrs_pin_sync #(.RST_VAL(1'b1)) u_ss_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(slave_select_pin),
    .level(ss_level)
  );

  // Writes are dropped once protection is on
  assign ram_wr = reg_wr && is_ram(reg_addr) && !s_q.protect && hw_run
                  && (s_q.state != MRS_HOLD);

  mrs_dsp_ram u_ram (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(ram_clear),
    .wr(ram_wr),
    .waddr(ram_index(reg_addr)),
    .wdata(reg_wdata),
    .raddr(ram_index(reg_addr)),
    .rdata(ram_rdata)
  );

  assign inc[0] = active_energy_inc;
  assign inc[1] = reactive_energy_inc;
  assign inc[2] = apparent_energy_inc;
  assign acc_rd[0] = reg_rd && (reg_addr == MRS_ACT_ACC);
  assign acc_rd[1] = reg_rd && (reg_addr == MRS_REACT_ACC);
  assign acc_rd[2] = reg_rd && (reg_addr == MRS_APP_ACC);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_d = s_q;
    ram_clear = 1'b0;
    clock_on = 1'b0;
    s_d.div = s_q.div + 2'h1;
    s_d.rvalid = 1'b0;
    s_d.ss_prev = ss_level;
    if (!hw_run) begin
      // Everything to default, port back to I2C, lock released
      s_d = MRS_SEQ_RST;
      s_d.div = s_q.div + 2'h1;
      ram_clear = 1'b1;
    end else begin
      // Register reads
      if (reg_rd) begin
        s_d.rvalid = 1'b1;
        s_d.ram_sel = is_ram(reg_addr);
        case (reg_addr)
          MRS_DSP_RUN: s_d.rdata = {31'h0000_0000, s_q.run};
          MRS_ACT_ACC: s_d.rdata = s_q.acc[0];
          MRS_REACT_ACC: s_d.rdata = s_q.acc[1];
          MRS_APP_ACC: s_d.rdata = s_q.acc[2];
          MRS_STATUS_ONE: s_d.rdata = {16'h0000, s_q.rdone, 15'h0000};
          MRS_PULSE_MODE: s_d.rdata = {16'h0000, s_q.pmode};
          MRS_CHIP_SETUP: s_d.rdata = {16'h0000, s_q.csetup};
          MRS_THIRD_SETUP: s_d.rdata = {24'h00_0000, s_q.cfg3};
          MRS_SERIAL_LOCK: s_d.rdata = {30'h0000_0000, s_q.spi, s_q.locked};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
      // Accumulators: a read clears, an increment in the same cycle is kept
      for (int i = 0; i < 3; i++) begin
        s_d.acc[i] = (acc_rd[i] ? 32'h0000_0000 : s_q.acc[i]) + inc[i];
      end
      // Slave-select toggles switch an unlocked I2C port to SPI
      if (s_q.state != MRS_HOLD && !s_q.locked && !s_q.spi && s_q.ss_prev && !ss_level) begin
        if (s_q.ss_cnt == MRS_SS_SPI_COUNT - 2'h1) begin
          s_d.spi = 1'b1;
          s_d.ss_cnt = 2'h0;
        end else begin
          s_d.ss_cnt = s_q.ss_cnt + 2'h1;
        end
      end
      // Register writes, ignored while the hardware reset sequence runs
      if (reg_wr && s_q.state != MRS_HOLD && !(s_q.state == MRS_SEQ && s_q.is_hw)) begin
        case (reg_addr)
          MRS_DSP_RUN: s_d.run = (reg_wdata[15:0] == MRS_RUN_START);
          MRS_STATUS_ONE: begin
            if (reg_wdata[MRS_RDONE_BIT]) begin
              s_d.rdone = 1'b0;
            end
          end
          MRS_PULSE_MODE: s_d.pmode = reg_wdata[15:0];
          MRS_CHIP_SETUP: s_d.csetup = reg_wdata[15:0];
          MRS_THIRD_SETUP: s_d.cfg3 = reg_wdata[7:0];
          MRS_PROT_KEY1: s_d.key_armed = (reg_wdata[7:0] == MRS_KEY1_VAL);
          MRS_PROT_KEY2: begin
            if (s_q.key_armed && reg_wdata[7:0] == MRS_KEY2_VAL) begin
              s_d.protect = 1'b1;
            end
            s_d.key_armed = 1'b0;
          end
          MRS_SERIAL_LOCK: begin
            if (!s_q.locked) begin
              if (s_q.spi) begin
                s_d.locked = 1'b1;
              end else if (reg_wdata[MRS_LOCK_BIT]) begin
                s_d.locked = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
      // Sequencer; its updates follow the writes so they win over a write in the same cycle
      case (s_q.state)
        MRS_HOLD: begin
          if (s_q.div == MRS_DIV_LAST) begin
            s_d.state = MRS_SEQ;
            s_d.is_hw = 1'b1;
            s_d.is_chip = 1'b0;
            s_d.cnt = 3'h0;
          end
        end
        MRS_SEQ: begin
          if (s_q.div == MRS_DIV_LAST) begin
            if (s_q.cnt == MRS_TOG_LAST) begin
              s_d.state = MRS_RUN;
              if (s_q.is_hw || s_q.is_chip) begin
                s_d.rdone = 1'b1;
              end
              if (s_q.is_chip) begin
                s_d.csetup[MRS_SOFTWARE_RESET_BIT_BIT] = 1'b0;
              end
              if (!s_q.is_hw && !s_q.is_chip) begin
                s_d.cfg3[MRS_REMRST_BIT] = 1'b0;
              end
            end else begin
              s_d.cnt = s_q.cnt + 3'h1;
            end
          end
        end
        MRS_RUN: begin
          if (s_q.cfg3[MRS_REMRST_BIT] && s_q.cfg3[MRS_CLKDIS_BIT]) begin
            s_d.state = MRS_LOWPWR;
          end else if (s_q.div == MRS_DIV_LAST && s_q.csetup[MRS_SOFTWARE_RESET_BIT_BIT]) begin
            // Whole-chipset reset keeps a locked port selection
            s_d = MRS_SEQ_RST;
            s_d.div = s_q.div + 2'h1;
            s_d.locked = s_q.locked;
            s_d.spi = s_q.locked && s_q.spi;
            s_d.acc = s_q.acc;
            s_d.ss_prev = ss_level;
            s_d.csetup[MRS_SOFTWARE_RESET_BIT_BIT] = 1'b1;
            s_d.state = MRS_SEQ;
            s_d.is_hw = 1'b0;
            s_d.is_chip = 1'b1;
            ram_clear = 1'b1;
          end else if (s_q.div == MRS_DIV_LAST && s_q.cfg3[MRS_REMRST_BIT]) begin
            s_d.state = MRS_SEQ;
            s_d.is_hw = 1'b0;
            s_d.is_chip = 1'b0;
            s_d.cnt = 3'h0;
          end
        end
        MRS_LOWPWR: begin
          if (!s_q.cfg3[MRS_REMRST_BIT] && !s_q.cfg3[MRS_CLKDIS_BIT]) begin
            s_d.state = MRS_RUN;
          end
        end
        default: begin
          s_d.state = MRS_HOLD;
        end
      endcase
    end
    // Pin levels follow the next state
    clock_on = ((s_d.state == MRS_RUN) && !s_d.cfg3[MRS_CLKDIS_BIT])
               || ((s_d.state == MRS_SEQ) && !s_d.is_hw);
    s_d.rclk = clock_on ? ~s_d.div[1] : 1'b1;
    s_d.ren = !((s_d.state == MRS_SEQ) || (s_d.state == MRS_LOWPWR));
    s_d.tog = !((s_d.state == MRS_SEQ) && s_d.div[1]);
    s_d.rsync = (s_d.state == MRS_HOLD) ? 1'b1 : stream_sync;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= MRS_SEQ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = s_q.ram_sel ? ram_rdata : s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign remote_clock_output = s_q.rclk;
  assign remote_sync = s_q.rsync;
  assign remote_reset_en = s_q.ren;
  assign channel_a_toggle = s_q.tog;
  assign channel_b_toggle = s_q.tog;
  assign channel_c_toggle = s_q.tog;
  assign neutral_toggle = s_q.tog;
  assign interrupt_one_output_n = ~s_q.rdone;
  assign spi_selected = s_q.spi;
  assign port_locked = s_q.locked;
  assign dsp_running = s_q.run;
  assign pulse_out_en = ~s_q.pmode[MRS_PO1_DIS_BIT +: 3];
  assign ram_protected = s_q.protect;
  assign low_power = (s_q.state == MRS_LOWPWR);
  assign seq_state = s_q.state;

endmodule

`default_nettype wire

// ---- tb/mrs_sequencer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module mrs_sequencer_sva
  import mrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic remote_clock_output,
  input wire logic remote_reset_en,
  input wire logic channel_a_toggle,
  input wire logic channel_b_toggle,
  input wire logic channel_c_toggle,
  input wire logic neutral_toggle,
  input wire logic interrupt_one_output_n,
  input wire logic dsp_running,
  input wire logic low_power,
  input wire mrs_pkg::mrs_state_e seq_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////
  logic [7:0] seq_cnt_q;
  logic [3:0] fall_cnt_q;
  logic tog_q;
  logic w1c_q;
  logic w1c;
  assign w1c = reg_wr && reg_addr == MRS_STATUS_ONE && reg_wdata[MRS_RDONE_BIT];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seq_cnt_q <= 8'h00;
      fall_cnt_q <= 4'h0;
      tog_q <= 1'b1;
      w1c_q <= 1'b0;
    end else begin
      tog_q <= channel_a_toggle;
      w1c_q <= w1c;
      seq_cnt_q <= (seq_state == MRS_SEQ) ? seq_cnt_q + 8'h01 : 8'h00;
      fall_cnt_q <= (seq_state == MRS_SEQ) ? fall_cnt_q + 4'(tog_q & ~channel_a_toggle) : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////
  property p_read_answer; reg_rd |=> reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read unanswered");
  property p_hold_lines;
    seq_state == MRS_HOLD |-> remote_clock_output && remote_reset_en && channel_a_toggle;
  endproperty
  a_hold_lines: assert property (p_hold_lines) else $error("hold lines wrong");
  property p_toggles_equal;
    {channel_b_toggle, channel_c_toggle, neutral_toggle} == {3{channel_a_toggle}};
  endproperty
  a_toggles_equal: assert property (p_toggles_equal) else $error("toggles differ");
  property p_seq_enable; seq_state == MRS_SEQ |-> !remote_reset_en; endproperty
  a_seq_enable: assert property (p_seq_enable) else $error("enable high in sequence");
  property p_seq_length;
    $fell(seq_state == MRS_SEQ) |-> seq_cnt_q == 8'h20 && fall_cnt_q == 4'h8;
  endproperty
  a_seq_length: assert property (p_seq_length) else $error("sequence length");
  property p_run_lines; seq_state == MRS_RUN |-> remote_reset_en && channel_a_toggle; endproperty
  a_run_lines: assert property (p_run_lines) else $error("run lines wrong");
  property p_lowpwr_lines;
    seq_state == MRS_LOWPWR |-> low_power && remote_clock_output && !remote_reset_en;
  endproperty
  a_lowpwr_lines: assert property (p_lowpwr_lines) else $error("low power lines");
  property p_lowpwr_entry;
    reg_wr && reg_addr == MRS_THIRD_SETUP && reg_wdata[7:6] == 2'b11 && seq_state == MRS_RUN
      |-> ##[1:3] seq_state == MRS_LOWPWR;
  endproperty
  a_lowpwr_entry: assert property (p_lowpwr_entry) else $error("no low power");
  property p_dsp_start;
    reg_wr && reg_addr == MRS_DSP_RUN && reg_wdata[15:0] == MRS_RUN_START && seq_state == MRS_RUN
      |-> ##[1:2] dsp_running;
  endproperty
  a_dsp_start: assert property (p_dsp_start) else $error("processor not started");
  property p_irq_release;
    $rose(interrupt_one_output_n) |-> w1c_q || $past(w1c_q) || seq_state != MRS_RUN;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq released alone");
  property p_irq_set; $fell(interrupt_one_output_n) |-> seq_state == MRS_RUN; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq set early");
  property p_clk_high;
    $rose(remote_clock_output) && seq_state == MRS_RUN |=> remote_clock_output;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high phase");
  c_seq_done: cover property ($fell(seq_state == MRS_SEQ));
  c_lowpwr: cover property (seq_state == MRS_LOWPWR);
  c_irq_release: cover property ($rose(interrupt_one_output_n));
endmodule

`default_nettype wire

// ---- tb/mrs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mrs_host_model (
  input wire logic mclk,
  input wire logic reg_rvalid,
  input wire logic [31:0] reg_rdata,
  output logic reset_pin_n,
  output logic slave_select_pin,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata
);
  ////////////////////////////////////////////////////////////
  initial begin
    reset_pin_n = 1'b1;
    slave_select_pin = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
  end
  // Released bus shows inverted values
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge mclk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
  task automatic hw_reset(input int cycles);
    reset_pin_n = 1'b0;
    repeat (cycles) @(posedge mclk);
    #1;
    reset_pin_n = 1'b1;
  endtask
  task automatic ss_toggle(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge mclk);
      #1;
      slave_select_pin = ~slave_select_pin;
    end
    repeat (6) @(posedge mclk);
    #1;
  endtask
endmodule

`default_nettype wire

// ---- tb/tb_metering_reset_init_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_metering_reset_init_sequencer;
  import mrs_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] inc = 32'h0;
  logic stream_sync = 1'b0;
  logic reset_pin_n, slave_select_pin, reg_wr, reg_rd, reg_rvalid;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic remote_clock_output, remote_sync, remote_reset_en, interrupt_one_output_n;
  logic channel_a_toggle, channel_b_toggle, channel_c_toggle, neutral_toggle;
  logic spi_selected, port_locked, dsp_running, ram_protected, low_power;
  logic [2:0] pulse_out_en;
  mrs_state_e seq_state;
  int error_cnt = 0;
  int cmp_count = 0;

  always #12.5 mclk = ~mclk;

  mrs_host_model host (.mclk, .reg_rvalid, .reg_rdata, .reset_pin_n, .slave_select_pin,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  mrs_sequencer dut (.mclk(mclk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .slave_select_pin(slave_select_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .active_energy_inc(inc), .reactive_energy_inc(inc),
    .apparent_energy_inc(inc), .stream_sync(stream_sync),
    .remote_clock_output(remote_clock_output), .remote_sync(remote_sync),
    .remote_reset_en(remote_reset_en), .channel_a_toggle(channel_a_toggle),
    .channel_b_toggle(channel_b_toggle), .channel_c_toggle(channel_c_toggle),
    .neutral_toggle(neutral_toggle), .interrupt_one_output_n(interrupt_one_output_n),
    .spi_selected(spi_selected), .port_locked(port_locked), .dsp_running(dsp_running),
    .pulse_out_en(pulse_out_en), .ram_protected(ram_protected), .low_power(low_power),
    .seq_state(seq_state));

  ////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic run_seq(input logic clk_runs);
    int n = 0, falls = 0, rises = 0;
    logic pt, pc;
    while (remote_reset_en !== 1'b0 && n < 40) begin
      step(1);
      n++;
    end
    n = 0;
    pt = 1'b1;
    pc = remote_clock_output;
    while (remote_reset_en === 1'b0 && n < 60) begin
      falls += int'(pt && !channel_a_toggle);
      rises += int'(!pc && remote_clock_output);
      pt = channel_a_toggle;
      pc = remote_clock_output;
      step(1);
      n++;
    end
    check(n == 32 && falls == 8, "remote sequence");
    check((rises > 0) === clk_runs, "clock in sequence");
    rises = 0;
    repeat (8) begin
      pc = remote_clock_output;
      step(1);
      rises += int'(!pc && remote_clock_output);
    end
    check(rises == 2, "clock after sequence");
  endtask
  task automatic t_flag();
    logic [31:0] d;
    step(20);
    check(interrupt_one_output_n === 1'b0, "irq held");
    host.rd(MRS_STATUS_ONE, d);
    check(d[MRS_RDONE_BIT] === 1'b1, "done flag");
    host.wr(MRS_STATUS_ONE, 32'h0000_8000);
    step(2);
    host.rd(MRS_STATUS_ONE, d);
    check(d[MRS_RDONE_BIT] === 1'b0 && interrupt_one_output_n === 1'b1, "clear");
  endtask
  task automatic t_defaults();
    logic [15:0] a [5] = '{MRS_PULSE_MODE, MRS_CHIP_SETUP, MRS_THIRD_SETUP, MRS_DSP_RUN,
      16'h1234};
    logic [31:0] e [5] = '{{16'h0, MRS_PULSE_MODE_RST}, {16'h0, MRS_CHIP_SETUP_RST},
      {24'h0, MRS_THIRD_SETUP_RST}, 32'h0, 32'h0};
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      host.rd(a[i], d);
      check(d === e[i], "register default");
    end
    check({dsp_running, pulse_out_en, ram_protected} === 5'h00, "idle");
  endtask
  task automatic t_config();
    logic [31:0] d;
    host.wr(MRS_DSP_RUN, {16'h0, MRS_RUN_START});
    step(2);
    check(dsp_running === 1'b1, "processor start");
    host.wr(MRS_A_IGAIN, 32'h1234_5678);
    repeat (3) host.wr(MRS_RAM_LAST, 32'hA5A5_0F0F);
    host.rd(MRS_A_IGAIN, d);
    check(d === 32'h1234_5678, "ram word");
    host.wr(MRS_PROT_KEY1, {24'h0, MRS_KEY1_VAL});
    host.wr(MRS_PROT_KEY2, {24'h0, MRS_KEY2_VAL});
    host.wr(MRS_RAM_LAST, 32'h0);
    host.rd(MRS_RAM_LAST, d);
    check(d === 32'hA5A5_0F0F && ram_protected === 1'b1, "ram protect");
    for (int i = 0; i < 3; i++) begin
      host.wr(MRS_PULSE_MODE, {16'h0, MRS_PULSE_MODE_RST & ~(16'h1 << (MRS_PO1_DIS_BIT + i))});
      step(2);
      check(pulse_out_en === 3'(1 << i), "pulse enable");
    end
    for (int i = 0; i < 3; i++) begin
      inc = 32'h5;
      step(4);
      inc = 32'h0;
      host.rd(MRS_ACT_ACC + 16'(i), d);
      check(d === 32'(20 * (i + 1)), "accumulated");
      host.rd(MRS_ACT_ACC + 16'(i), d);
      check(d === 32'h0, "read clears");
    end
  endtask
  task automatic t_lock();
    logic [31:0] d;
    host.ss_toggle(3);
    host.wr(MRS_SERIAL_LOCK, 32'h0);
    host.rd(MRS_SERIAL_LOCK, d);
    check(d[1:0] === 2'b11, "spi locked");
    fork
      host.hw_reset(400);
      begin
        step(100);
        check({remote_clock_output, remote_sync, remote_reset_en, channel_a_toggle,
          channel_b_toggle, channel_c_toggle, neutral_toggle} === 7'h7F, "hold");
      end
    join
    run_seq(1'b0);
    check({spi_selected, port_locked} === 2'b00, "i2c default");
    t_flag();
    t_defaults();
    host.wr(MRS_SERIAL_LOCK, 32'h0);
    step(2);
    check(port_locked === 1'b0, "lock needs bit0");
    host.wr(MRS_SERIAL_LOCK, 32'h1);
    host.ss_toggle(3);
    check({spi_selected, port_locked} === 2'b01, "i2c locked");
  endtask
  task automatic t_chip_reset();
    logic [31:0] d;
    host.wr(MRS_DSP_RUN, {16'h0, MRS_RUN_START});
    host.wr(MRS_PULSE_MODE, 32'h0);
    host.wr(MRS_CHIP_SETUP, 32'h80);
    run_seq(1'b1);
    host.rd(MRS_CHIP_SETUP, d);
    check(d[MRS_SOFTWARE_RESET_BIT_BIT] === 1'b0, "reset bit clear");
    host.rd(MRS_PULSE_MODE, d);
    check(d === {16'h0, MRS_PULSE_MODE_RST}, "defaults");
    check({dsp_running, port_locked, spi_selected} === 3'b010, "lock kept");
    t_flag();
  endtask
  task automatic t_remote_and_low_power();
    logic [31:0] d;
    host.wr(MRS_THIRD_SETUP, 32'h80);
    run_seq(1'b1);
    host.rd(MRS_THIRD_SETUP, d);
    check(d[MRS_REMRST_BIT] === 1'b0 && interrupt_one_output_n === 1'b1, "self clear");
    host.wr(MRS_PULSE_MODE, 32'h0);
    host.wr(MRS_THIRD_SETUP, 32'hC0);
    step(3);
    check({low_power, remote_clock_output, remote_reset_en} === 3'b110, "low power");
    step(8);
    check(remote_clock_output === 1'b1, "clock stopped");
    host.wr(MRS_THIRD_SETUP, 32'h0);
    step(3);
    host.rd(MRS_PULSE_MODE, d);
    check(low_power === 1'b0 && d === 32'h0, "config kept");
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    step(2);
    check({remote_clock_output, remote_sync, remote_reset_en, neutral_toggle} === 4'hF,
      "reset lines");
    rst_n = 1'b1;
    run_seq(1'b0);
    t_flag();
    t_defaults();
    t_config();
    t_lock();
    t_chip_reset();
    t_remote_and_low_power();
    stop_test();
  end
  initial begin
    #300000;
    error_cnt++;
    stop_test();
  end
endmodule

bind mrs_sequencer mrs_sequencer_sva u_sva (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rvalid, .remote_clock_output, .remote_reset_en, .channel_a_toggle,
  .channel_b_toggle, .channel_c_toggle, .neutral_toggle, .interrupt_one_output_n,
  .dsp_running, .low_power, .seq_state);

`default_nettype wire
